// ### edc_defs.svh
// constants for the sec-ded word protection datapath
`ifndef EDC_DEFS_SVH
`define EDC_DEFS_SVH

// code geometry
`define CHK_W        6
`define WORD_W       16

// participation masks, one per check bit
`define MASK_X       16'h4b2e
`define MASK_0       16'h1557
`define MASK_1       16'ha699
`define MASK_2       16'h38e3
`define MASK_4       16'hc0fc
`define MASK_8       16'hff00

// register byte offsets
`define REG_CTRL     8'h00
`define REG_STATUS   8'h04
`define REG_MASK     8'h08
`define REG_SYN      8'h0c
`define REG_COUNT    8'h10

// field positions
`define CTRL_CORRECT 0
`define ST_DATA      0
`define ST_CHECK     1
`define ST_DOUBLE    2
`define ST_MULTI     3

// reset values
`define CTRL_RESET   1'h1
`define MASK_RESET   4'h0
`define STATUS_RESET 4'h0
`define COUNT_RESET  16'h0000

`endif

// ### edc_pkg.sv
// types shared by the sec-ded word protection datapath
package edc_pkg;

   // position of a device in a two-device cascade
   typedef enum logic [1:0]
   {
      POS_ALONE  = 2'b00,
      POS_FIRST  = 2'b10,
      POS_SECOND = 2'b11
   } pos_code_t;

   // classification of a syndrome, one-hot
   typedef enum logic [3:0]
   {
      CLS_NONE   = 4'b0001,
      CLS_SINGLE = 4'b0010,
      CLS_DOUBLE = 4'b0100,
      CLS_MULTI  = 4'b1000
   } err_class_t;

endpackage

// ### secded_edc_datapath.sv
// sec-ded check generation, syndrome, correction and register port
`timescale 1ns/10ps
`include "edc_defs.svh"

module secded_edc_datapath
   import edc_pkg::*;
#(
   parameter int DATA_W = 16
)
(
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   // operation strobes
   input  wire logic                  wr_gen,
   input  wire logic                  rd_check,
   input  wire logic                  wr_merge,
   input  wire logic                  apply_syn,
   input  wire logic [DATA_W/8-1:0]   merge_byte,
   input  wire logic [DATA_W/8-1:0]   byte_oe,
   input  wire logic [1:0]            cascade_position_code,
   // data pins
   input  wire logic [DATA_W-1:0]     data_in,
   output logic      [DATA_W-1:0]     data_out,
   output logic      [DATA_W/8-1:0]   data_oe,
   // check and syndrome pins
   input  wire logic [`CHK_W-1:0]     check_in,
   output logic      [`CHK_W-1:0]     check_out,
   output logic      [`CHK_W-1:0]     syndrome,
   output logic      [3:0]            err_class,
   // interrupt
   output logic                       irq
);

   localparam int NB = DATA_W / 8;

   // the check tables exist only for a sixteen-bit slice
   if (DATA_W != `WORD_W)
   begin : g_width_check
      $error("secded_edc_datapath: DATA_W must be 16");
   end

   // even xor checks; odd xnor checks; even xor checks
   // bit order x,0,1,2,4,8 from msb down
   function automatic logic [`CHK_W-1:0] gen_check(input logic [15:0] d);
      gen_check = { ^(d & `MASK_X), ^(d & `MASK_0), ~^(d & `MASK_1),
                    ~^(d & `MASK_2), ^(d & `MASK_4), ^(d & `MASK_8) };
   endfunction

   // column of check bits a data bit takes part in
   function automatic logic [`CHK_W-1:0] column(input int n);
      logic [15:0] mx;
      logic [15:0] m0;
      logic [15:0] m1;
      logic [15:0] m2;
      logic [15:0] m4;
      logic [15:0] m8;
      mx = `MASK_X;
      m0 = `MASK_0;
      m1 = `MASK_1;
      m2 = `MASK_2;
      m4 = `MASK_4;
      m8 = `MASK_8;
      column = { mx[n], m0[n], m1[n], m2[n], m4[n], m8[n] };
   endfunction

   // data bit whose column equals the syndrome
   function automatic logic [15:0] flip_mask(input logic [`CHK_W-1:0] s);
      flip_mask = 16'h0000;
      for (int i = 0; i < 16; i++)
         flip_mask[i] = (s == column(i));
   endfunction

   // zero and one-hot syndromes; even and unmatched odd weights
   function automatic logic [3:0] classify(input logic [`CHK_W-1:0] s);
      if (s == '0)
         classify = CLS_NONE;
      else if (!(^s))
         classify = CLS_DOUBLE;
      else if ($onehot(s) || (|flip_mask(s)))
         classify = CLS_SINGLE;
      else
         classify = CLS_MULTI;
   endfunction

   // state
   logic [DATA_W-1:0]  data_q;
   logic [`CHK_W-1:0]  check_q;
   logic [`CHK_W-1:0]  syn_q;
   logic [3:0]         class_q;
   logic               correct_q;
   logic [3:0]         status_q;
   logic [3:0]         status_d;
   logic [3:0]         mask_q;
   logic [15:0]        count_q;
   logic [15:0]        count_d;
   logic [31:0]        rdata_q;
   logic [31:0]        rdata_d;

   // decoded datapath terms
   wire pos_code_t          pos        = pos_code_t'(cascade_position_code);
   wire logic               is_first   = (pos == POS_FIRST);
   // syndrome from regenerated and stored check bits
   wire logic [`CHK_W-1:0]  syn_now    = gen_check(data_in) ^ check_in;
   // the first device's final syndrome comes back on check_in
   wire logic [`CHK_W-1:0]  syn_use    = apply_syn ? check_in : syn_now;
   wire logic [DATA_W-1:0]  base_word  = apply_syn ? data_q : data_in;
   wire logic [3:0]         cls_now    = classify(syn_use);
   // invert the located bit; raw word when correction is off
   wire logic [DATA_W-1:0]  fixed_word =
      correct_q ? (base_word ^ flip_mask(syn_use)) : base_word;
   // the first device only forms a partial syndrome on the read
   wire logic               judge      = apply_syn || (rd_check && !is_first);
   logic [DATA_W-1:0]       merged;

   // byte merge of new bytes over the corrected latch
   for (genvar b = 0; b < NB; b++)
   begin : g_byte
      assign merged[b*8 +: 8] =
         merge_byte[b] ? data_in[b*8 +: 8] : data_q[b*8 +: 8];
      assign data_oe[b] = byte_oe[b];
   end

   // data latch and check outputs
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         data_q  <= '0;
         check_q <= '0;
      end
      else if (wr_gen)
      begin
         data_q  <= data_in;
         check_q <= gen_check(data_in);
      end
      else if (wr_merge)
      begin
         // latch already holds the corrected read word
         data_q  <= merged;
         check_q <= gen_check(merged);
      end
      else if (rd_check && is_first)
         data_q  <= data_in;
      else if (judge)
         // corrected word into the output latch
         data_q  <= fixed_word;
   end

   // syndrome and classification latches
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         syn_q   <= '0;
         class_q <= CLS_NONE;
      end
      else if (rd_check || apply_syn)
      begin
         syn_q   <= syn_use;
         class_q <= judge ? cls_now : CLS_NONE;
      end
   end

   // second device forms its syndrome straight from the open check input
   // six check bits per sixteen-bit word
   assign check_out = check_q;
   assign data_out  = data_q;
   assign syndrome  = syn_q;
   assign err_class = class_q;

   // register decode
   wire logic wr_ctrl   = reg_wr && (reg_addr == `REG_CTRL);
   wire logic wr_status = reg_wr && (reg_addr == `REG_STATUS);
   wire logic wr_mask   = reg_wr && (reg_addr == `REG_MASK);
   wire logic wr_count  = reg_wr && (reg_addr == `REG_COUNT);

   // events of a judged read, set wins over a write-one clear
   wire logic       ev_data  = judge && (cls_now == CLS_SINGLE)
                               && (|flip_mask(syn_use));
   wire logic       ev_check = judge && (cls_now == CLS_SINGLE)
                               && $onehot(syn_use);
   wire logic       ev_dbl   = judge && (cls_now == CLS_DOUBLE);
   wire logic       ev_multi = judge && (cls_now == CLS_MULTI);
   wire logic [3:0] ev_set   = { ev_multi, ev_dbl, ev_check, ev_data };
   wire logic [3:0] clr_bits = wr_status ? reg_wdata[3:0] : 4'h0;

   // status and count next values
   always_comb
   begin
      status_d = (status_q & ~clr_bits) | ev_set;
      count_d  = count_q;
      if (wr_count)
         count_d = `COUNT_RESET;
      if ((|ev_set) && (count_q != 16'hffff))
         count_d = count_d + 16'h0001; // saturates rather than wraps
   end

   // read mux, zero for unmapped addresses
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `REG_CTRL:   rdata_d[`CTRL_CORRECT] = correct_q;
            `REG_STATUS: rdata_d[3:0] = status_q;
            `REG_MASK:   rdata_d[3:0] = mask_q;
            `REG_SYN:    rdata_d[`CHK_W-1:0] = syn_q;
            `REG_COUNT:  rdata_d[15:0] = count_q;
            default:     rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // software registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         correct_q <= `CTRL_RESET;
         status_q  <= `STATUS_RESET;
         mask_q    <= `MASK_RESET;
         count_q   <= `COUNT_RESET;
         rdata_q   <= 32'h0000_0000;
      end
      else
      begin
         if (wr_ctrl)
            correct_q <= reg_wdata[`CTRL_CORRECT];
         if (wr_mask)
            mask_q <= reg_wdata[3:0];
         status_q <= status_d;
         count_q  <= count_d;
         rdata_q  <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   // level interrupt while any unmasked status bit is set
   assign irq = |(status_q & mask_q);

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   gen_write_a: assert property (
      wr_gen |=> check_out == gen_check($past(data_in)))
      else $error("write check bits wrong");

   merge_check_a: assert property (
      wr_merge |=> check_out == gen_check(data_out))
      else $error("merged check bits wrong");

   syndrome_form_a: assert property (
      (rd_check && !apply_syn) |=> syndrome == $past(syn_now))
      else $error("syndrome not formed from read");

   no_error_a: assert property (
      (rd_check && !apply_syn && !is_first && syn_now == '0)
      |=> err_class == CLS_NONE && data_out == $past(data_in))
      else $error("clean read altered");

   double_flag_a: assert property (
      (rd_check && !apply_syn && !is_first && syn_now != '0 && !(^syn_now))
      |=> err_class == CLS_DOUBLE && data_out == $past(data_in))
      else $error("double error not flagged");

   bit15_fix_a: assert property (
      (rd_check && !apply_syn && !is_first && correct_q
       && syn_now == 6'h0b)
      |=> data_out[15] != $past(data_in[15]))
      else $error("bit 15 not corrected");

   corrected_latch_a: assert property (
      (rd_check && !apply_syn && !is_first && correct_q)
      |=> data_out == ($past(data_in) ^ flip_mask(syndrome)))
      else $error("corrected word not latched");

   raw_pass_a: assert property (
      (rd_check && !apply_syn && !correct_q) |=> data_out == $past(data_in))
      else $error("raw read altered");

   first_hold_a: assert property (
      (rd_check && is_first && !apply_syn) |=> err_class == CLS_NONE
      && data_out == $past(data_in))
      else $error("first device corrected early");

   irq_event_a: assert property (
      (ev_data && mask_q[`ST_DATA] && !wr_mask)
      |=> irq && status_q[`ST_DATA])
      else $error("event did not raise interrupt");

   single_cov: cover property (rd_check ##1 err_class == CLS_SINGLE);
   double_cov: cover property (rd_check ##1 err_class == CLS_DOUBLE);
   // the host lets one idle cycle pass between steps, so allow a gap
   rmw_cov:    cover property (rd_check ##[1:2] wr_merge);
   cascade_cov: cover property (rd_check && is_first ##[1:2] apply_syn);

endmodule

// ### mem_array_model.sv
// memory array model on the far side of the protection datapath
`timescale 1ns/10ps

module mem_array_model
(
   // clock
   input  wire logic        core_clk,
   // write side, fed from the datapath outputs
   input  wire logic        mem_wr,
   input  wire logic [3:0]  mem_addr,
   input  wire logic [15:0] wdata,
   input  wire logic [5:0]  wcheck,
   // read side, fault pattern applied on the way out
   input  wire logic        mem_rd,
   input  wire logic [21:0] flip,
   output logic      [15:0] rdata,
   output logic      [5:0]  rcheck
);
   logic [21:0] word_q [16];
   logic [21:0] last_q;
   logic [21:0] rd_word;

   // merged word kept with its checks
   always_ff @(posedge core_clk)
   begin
      if (mem_wr)
         word_q[mem_addr] <= {wdata, wcheck};
      last_q <= {rdata, rcheck};
   end

   // deselected lines toggle each cycle so a stale copy is never seen
   assign rd_word = word_q[mem_addr] ^ flip;
   assign {rdata, rcheck} = mem_rd ? rd_word : ~last_q;
endmodule

// ### tb.sv
// self-checking bench for the sec-ded word protection datapath
`timescale 1ns/10ps
`include "edc_defs.svh"

module tb
   import edc_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, irq, mode = 1'b1;
   logic        wr_gen = 1'b0, rd_check = 1'b0, wr_merge = 1'b0;
   logic        apply_syn = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0;
   logic [1:0]  merge_byte = 2'h0, byte_oe = 2'h0, pos = 2'h0, data_oe;
   logic [15:0] host_data = 16'h0, data_in, data_out, mdata, d;
   logic [5:0]  host_check = 6'h0, check_in, check_out, syndrome, mcheck;
   logic [3:0]  err_class, st = 4'h0;
   logic [21:0] flip = 22'h0, f;
   int          seed = 28580, fails = 0, tests_run = 0, cycles = 0, b;
   int          n_ev = 0;

   // data lines come from the array while it is read, else from the host
   assign data_in = mem_rd ? mdata : host_data;
   assign check_in = mem_rd ? mcheck : host_check;

   secded_edc_datapath secded_edc_datapath_inst (.core_clk(core_clk),
      .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wr_gen(wr_gen), .rd_check(rd_check), .wr_merge(wr_merge),
      .apply_syn(apply_syn), .merge_byte(merge_byte), .byte_oe(byte_oe),
      .cascade_position_code(pos), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .check_in(check_in),
      .check_out(check_out), .syndrome(syndrome),
      .err_class(err_class), .irq(irq));

   mem_array_model mem_array_model_inst (.core_clk(core_clk),
      .mem_wr(mem_wr), .mem_addr(4'h3), .wdata(data_out),
      .wcheck(check_out), .mem_rd(mem_rd), .flip(flip), .rdata(mdata),
      .rcheck(mcheck));

   // 200 mhz clock and hang guard
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         report_and_stop();
      end
   end

   function automatic logic [5:0] gen(input logic [15:0] x);
      gen = {^(x & 16'h4b2e), ^(x & 16'h1557), ~^(x & 16'ha699),
             ~^(x & 16'h38e3), ^(x & 16'hc0fc), ^(x & 16'hff00)};
   endfunction

   // flip the data bit whose column equals the syndrome
   function automatic logic [15:0] fix(input logic [15:0] x,
                                       input logic [5:0] s);
      fix = x;
      for (int n = 0; n < 16; n++)
         if ((gen(16'h1 << n) ^ gen(16'h0)) == s)
            fix[n] = ~x[n];
   endfunction

   function automatic logic [3:0] cls(input logic [5:0] s);
      if (s == 6'h00)
         return CLS_NONE;
      if ($countones(s) == 1 || fix(16'h0, s) != 16'h0)
         return CLS_SINGLE;
      return ($countones(s) % 2 == 0) ? CLS_DOUBLE : CLS_MULTI;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] x);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] x);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      x = reg_rdata;
   endtask

   // k: 0 generate, 1 merge, 2 host read, 3 syndrome, 4 array read
   task automatic op(input int k, input logic [15:0] x,
                     input logic [5:0] c, input logic [21:0] fl);
      @(posedge core_clk);
      host_data <= x;
      host_check <= c;
      flip <= fl;
      mem_rd <= (k == 4);
      wr_gen <= (k == 0);
      wr_merge <= (k == 1);
      rd_check <= (k == 2 || k == 4);
      apply_syn <= (k == 3);
      @(posedge core_clk);
      {wr_gen, wr_merge, rd_check, apply_syn, mem_rd} <= 5'h00;
      #1;
   endtask

   task automatic write_word(input logic [15:0] x);
      op(0, x, 6'h00, 22'h0);
      // checks made from the incoming word
      chk(check_out, gen(x));
      @(posedge core_clk);
      mem_wr <= 1'b1;
      @(posedge core_clk);
      mem_wr <= 1'b0;
   endtask

   task automatic judge(input logic [15:0] r, input logic [5:0] rc);
      logic [5:0] s;
      logic [3:0] e;
      s = gen(r) ^ rc;
      e = cls(s);
      chk(syndrome, s);
      chk(err_class, e);
      chk(data_out, mode ? fix(r, s) : r);
      if (e != CLS_NONE)
         n_ev++;
      if (e == CLS_SINGLE)
         st |= ($countones(s) == 1) ? 4'h2 : 4'h1;
      else if (e != CLS_NONE)
         st |= (e == CLS_DOUBLE) ? 4'h4 : 4'h8;
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({data_out, check_out, syndrome, err_class}, 32'h1);
      chk(irq, 1'b0);
      chk(reg_rdata, 32'h0);
      reg_read(`REG_CTRL, rv);
      chk(rv, 32'h1);
      reg_write(`REG_MASK, 32'h5);
      reg_read(`REG_MASK, rv);
      chk(rv, 32'h5);
      write_word(16'hffff);
      chk(check_out, 6'h0c);
      // random words with none, data, check, double and triple faults
      for (int i = 0; i < 40; i++)
      begin
         d = 16'($random(seed));
         b = $random(seed) & 32'hf;
         write_word(d);
         f = (i % 5 == 1) ? 22'h40 << b : (i % 5 == 2) ? 22'h1 << (b % 6)
           : (i % 5 == 3) ? 22'hc0 << b : (i % 5 == 4) ? 22'h1c0 << b
           : 22'h0;
         if (i == 30)
         begin
            reg_write(`REG_CTRL, 32'h0);
            mode = 1'b0;
         end
         @(posedge core_clk);
         byte_oe <= 2'($random(seed));
         op(4, 16'h0, 6'h00, f);
         chk(data_oe, byte_oe);
         judge(d ^ f[21:6], gen(d) ^ f[5:0]);
      end
      // correcting read, then merge of the upper byte
      reg_write(`REG_CTRL, 32'h1);
      mode = 1'b1;
      d = 16'h5a3c;
      write_word(d);
      op(4, 16'h0, 6'h00, 22'h200);
      judge(d ^ 16'h0008, gen(d));
      merge_byte <= 2'b10;
      op(1, 16'hc700, 6'h00, 22'h0);
      chk(data_out, 16'hc73c);
      chk(check_out, gen(16'hc73c));
      // status, mask, interrupt, syndrome readback, unmapped place
      reg_read(`REG_STATUS, rv);
      chk(rv, {28'h0, st});
      chk(irq, |(st & 4'h5));
      // every judged read with a fault counts once
      reg_read(`REG_COUNT, rv);
      chk(rv, n_ev);
      reg_write(`REG_COUNT, 32'h0);
      reg_read(`REG_COUNT, rv);
      chk(rv, 32'h0);
      reg_write(`REG_STATUS, 32'hf);
      reg_read(`REG_STATUS, rv);
      chk(rv, 32'h0);
      @(posedge core_clk);
      #1;
      chk(irq, 1'b0);
      reg_read(`REG_SYN, rv);
      chk(rv, {26'h0, gen(d ^ 16'h0008) ^ gen(d)});
      reg_read(8'h20, rv);
      chk(rv, 32'h0);
      // first cascade slice: partial syndrome, then correction
      pos <= 2'b10;
      d = 16'h9e01;
      op(2, d ^ 16'h0400, gen(d), 22'h0);
      chk(syndrome, gen(d ^ 16'h0400) ^ gen(d));
      chk({data_out, err_class}, {d ^ 16'h0400, CLS_NONE});
      op(3, 16'h0, gen(16'h0400) ^ gen(16'h0), 22'h0);
      chk({data_out, err_class}, {d, CLS_SINGLE});
      // second slice judges and corrects in one step
      pos <= 2'b11;
      op(2, d ^ 16'h8000, gen(d), 22'h0);
      judge(d ^ 16'h8000, gen(d));
      report_and_stop();
   end
endmodule
